// ===== test/rlc_checker.sv
// Purpose: Port assertions for the link register subset
// Assumes: Bound to rlc_regs
// Notes: Mirrors reset-control writes to judge the reset bit
`timescale 1ns/100ps
// ==========================================
// Checker
module rlc_checker (
   // Clock and reset
   input wire CLK,
   input wire RST_N,
   // CPU port
   input wire [7:0] CPU_ADDR,
   input wire CPU_WR,
   input wire [31:0] CPU_WDATA,
   input wire [31:0] CPU_RDATA,
   input wire CPU_RVALID,
   // Loop and reset word
   input wire [2:0] FRAME_LOOP_MODE_IN,
   input wire [2:0] FRAME_LOOP_MODE,
   input wire TX_RESET_BIT,
   input wire EXTERNAL_RESET_REQUEST_IN,
   input wire PHY_LOOP,
   // Management settings
   input wire [2:0] SEND_SLOW_MGMT_RATE,
   input wire [5:0] SEND_FAST_MGMT_POINTER,
   input wire [2:0] ACCEPTED_SLOW_MGMT_RATE,
   input wire SLOW_RATE_ACCEPTED,
   input wire [5:0] ACCEPTED_FAST_MGMT_POINTER,
   input wire FAST_POINTER_ACCEPTED
);
   reg [3:0] ctl_q;
   wire [2:0] w_slow = CPU_WDATA[10:8];
   wire [5:0] w_fast = CPU_WDATA[5:0];
   wire w_loop = CPU_WDATA[0];
   always @(posedge CLK) begin
      if (!RST_N)
         ctl_q <= 4'h0;
      else if (CPU_WR && CPU_ADDR == 8'h20)
         ctl_q <= CPU_WDATA[3:0];
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   loop_override_a: assert property (
      FRAME_LOOP_MODE == (PHY_LOOP ? 3'h0 : FRAME_LOOP_MODE_IN)) else $error("loop mode wrong");
   sw_reset_bit_a: assert property (
      !ctl_q[3] |-> TX_RESET_BIT == (ctl_q[0] & ctl_q[1])) else $error("sw reset bit wrong");
   pin_reset_bit_a: assert property (
      ctl_q[3] && $past(ctl_q[3], 2) |-> TX_RESET_BIT == $past(EXTERNAL_RESET_REQUEST_IN, 2))
      else $error("pin reset bit wrong");
   cfg_out_a: assert property (
      CPU_WR && CPU_ADDR == 8'h28 |=> SEND_SLOW_MGMT_RATE == $past(w_slow)
      && SEND_FAST_MGMT_POINTER == $past(w_fast)) else $error("config not sent");
   fast_default_a: assert property (
      $rose(RST_N) |-> SEND_FAST_MGMT_POINTER == 6'h14) else $error("pointer default wrong");
   loop_select_a: assert property (
      CPU_WR && CPU_ADDR == 8'h24 |=> PHY_LOOP == $past(w_loop)) else $error("loop not set");
   fast_range_a: assert property (
      FAST_POINTER_ACCEPTED |-> ACCEPTED_FAST_MGMT_POINTER inside {[6'h24:6'h3F]})
      else $error("pointer out of range");
   slow_code_a: assert property (
      SLOW_RATE_ACCEPTED |-> ACCEPTED_SLOW_MGMT_RATE != 3'h7) else $error("bad slow code");
   slow_sticky_a: assert property (
      SLOW_RATE_ACCEPTED |=> SLOW_RATE_ACCEPTED) else $error("slow valid dropped");
   reserved_zero_a: assert property (
      CPU_RVALID |-> CPU_RDATA[31:12] == 20'h0) else $error("reserved bits set");
   cover property (FAST_POINTER_ACCEPTED && SLOW_RATE_ACCEPTED);
   cover property (ctl_q[3] && TX_RESET_BIT);
   cover property (PHY_LOOP && FRAME_LOOP_MODE_IN != 3'h0);
endmodule
bind rlc_regs rlc_checker chk_u (.CLK(CLK), .RST_N(RST_N), .CPU_ADDR(CPU_ADDR),
   .CPU_WR(CPU_WR), .CPU_WDATA(CPU_WDATA), .CPU_RDATA(CPU_RDATA), .CPU_RVALID(CPU_RVALID),
   .FRAME_LOOP_MODE_IN(FRAME_LOOP_MODE_IN), .FRAME_LOOP_MODE(FRAME_LOOP_MODE),
   .TX_RESET_BIT(TX_RESET_BIT), .EXTERNAL_RESET_REQUEST_IN(EXTERNAL_RESET_REQUEST_IN),
   .PHY_LOOP(PHY_LOOP), .SEND_SLOW_MGMT_RATE(SEND_SLOW_MGMT_RATE),
   .SEND_FAST_MGMT_POINTER(SEND_FAST_MGMT_POINTER),
   .ACCEPTED_SLOW_MGMT_RATE(ACCEPTED_SLOW_MGMT_RATE), .SLOW_RATE_ACCEPTED(SLOW_RATE_ACCEPTED),
   .ACCEPTED_FAST_MGMT_POINTER(ACCEPTED_FAST_MGMT_POINTER),
   .FAST_POINTER_ACCEPTED(FAST_POINTER_ACCEPTED));

// ===== test/rlc_link_model.sv
// Purpose: Far end of the link, sending decoded bytes
// Assumes: Receive clock only moves while a byte is sent
// Notes: Lines show inverted data between bytes
`timescale 1ns/100ps
// ==========================================
// Link partner
module rlc_link_model (
   // Receive stream
   output reg rx_clk,
   output reg rx_lcv,
   output reg [7:0] rx_idx,
   output reg [7:0] rx_data
);
   initial begin
      rx_clk = 1'b1;
      rx_lcv = 1'b0;
      rx_idx = 8'h00;
      rx_data = 8'h00;
   end
   task send(input [7:0] idx, input [7:0] data, input lcv);
      begin
         rx_clk = 1'b0;
         rx_idx = idx;
         rx_data = data;
         rx_lcv = lcv;
         #62.5 rx_clk = 1'b1;
         #62.5 rx_idx = ~idx;
         rx_data = ~data;
         rx_lcv = ~lcv;
      end
   endtask
   task hframe(input [2:0] slow, input rst, input [5:0] fast);
      begin
         send(8'h42, {5'h00, slow}, 1'b0);
         send(8'h82, {7'h00, rst}, 1'b0);
         send(8'hC2, {2'h0, fast}, 1'b0);
      end
   endtask
endmodule

// ===== test/tb.sv
// Purpose: Register-level tests of the link register subset
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Expected words built from the register layout
`timescale 1ns/100ps
// ==========================================
// Testbench
module tb;
   reg clk, rst_n, wr_s, rd_s, tx_stb, sent, ext;
   reg [7:0] addr, tx_in;
   reg [31:0] wdata;
   reg [11:0] bfn;
   reg [2:0] lin;
   wire [31:0] rdata;
   wire rvalid, rx_clk, rx_lcv, rbit, loop, rout;
   wire [7:0] rx_idx, rx_data, tx_out;
   wire [2:0] floop, slow;
   wire [5:0] fast;
   integer err_total = 0, n_compared = 0, cyc = 0, i;
   rlc_regs dut_u (.CLK(clk), .RST_N(rst_n), .CPU_ADDR(addr), .CPU_WR(wr_s), .CPU_RD(rd_s),
      .CPU_WDATA(wdata), .CPU_RDATA(rdata), .CPU_RVALID(rvalid), .RX_CLK(rx_clk),
      .RX_LCV(rx_lcv), .RX_CTRL_IDX(rx_idx), .RX_DATA(rx_data), .RX_BFN(bfn),
      .FRAME_LOOP_MODE_IN(lin), .FRAME_LOOP_MODE(floop), .TX_STB(tx_stb), .TX_DATA_IN(tx_in),
      .TX_DATA_OUT(tx_out), .TX_RESET_SENT(sent), .TX_RESET_BIT(rbit),
      .SEND_SLOW_MGMT_RATE(slow), .SEND_FAST_MGMT_POINTER(fast), .PHY_LOOP(loop),
      .EXTERNAL_RESET_REQUEST_IN(ext), .RESET_OUT(rout), .ACCEPTED_SLOW_MGMT_RATE(),
      .SLOW_RATE_ACCEPTED(), .ACCEPTED_FAST_MGMT_POINTER(), .FAST_POINTER_ACCEPTED());
   rlc_link_model lm_u (.rx_clk(rx_clk), .rx_lcv(rx_lcv), .rx_idx(rx_idx), .rx_data(rx_data));
   task chk(input string nm, input [32:0] seen, input [32:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk) #1 addr = a;
         wdata = d;
         wr_s = 1'b1;
         @(posedge clk) #1 wr_s = 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e, input string nm);
      begin
         @(posedge clk) #1 addr = a;
         rd_s = 1'b1;
         @(posedge clk) #1 rd_s = 1'b0;
         chk(nm, {rvalid, rdata}, {1'b1, e});
      end
   endtask
   task wrap_up;
      begin
         $display("Compared %0d, mismatches %0d", n_compared, err_total);
         if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Whole run is near 12000 cycles
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         err_total = err_total + 1;
         wrap_up;
      end
   end
   initial begin
      {rst_n, wr_s, rd_s, tx_stb, sent, ext} = 6'h00;
      addr = 8'h00;
      wdata = 32'h0;
      tx_in = 8'hC3;
      bfn = 12'hA5C;
      lin = 3'h5;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      // ==========================================
      // Reset values, read-only and reserved bits
      rd(8'h18, 32'h0, "lcv");
      rd(8'h1C, 32'hA5C, "bfn");
      rd(8'h20, 32'h0, "rstctl");
      rd(8'h28, 32'h14, "cmcfg");
      rd(8'h2C, 32'h0, "cmstat");
      rd(8'h30, 32'h0, "unmapped");
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C, 32'hA5C, "bfn");
      wr(8'h28, 32'hFFFF_FF3F);
      rd(8'h28, 32'h73F, "cmcfg");
      chk("slow", slow, 33'h7);
      chk("fast", fast, 33'h3F);
      wr(8'h24, 32'hFFFF_FFFF);
      rd(8'h24, 32'h1, "loop");
      chk("loop", loop, 33'h1);
      chk("floop", floop, 33'h0);
      // ==========================================
      // Management acceptance, every slow code
      for (i = 0; i < 7; i = i + 1) begin
         repeat (4) lm_u.hframe(i[2:0], 1'b0, 6'h3F - i[5:0]);
         rd(8'h2C, {20'h0, 1'b1, i[2:0], 2'h1, 6'h3F - i[5:0]}, "cmstat");
      end
      repeat (4) lm_u.hframe(3'h7, 1'b0, 6'h23);
      rd(8'h2C, 32'hE79, "cmstat");
      repeat (3) lm_u.hframe(3'h5, 1'b0, 6'h24);
      rd(8'h2C, 32'hE79, "cmstat");
      lm_u.hframe(3'h5, 1'b0, 6'h24);
      rd(8'h2C, 32'hD64, "cmstat");
      // ==========================================
      // Violation counter saturation
      repeat (3) lm_u.send(8'h00, 8'h00, 1'b1);
      rd(8'h18, 32'h3, "lcv");
      repeat (260) lm_u.send(8'h00, 8'h00, 1'b1);
      rd(8'h18, 32'hFF, "lcv");
      // ==========================================
      // Received reset request
      wr(8'h20, 32'h4);
      lm_u.hframe(3'h5, 1'b1, 6'h24);
      rd(8'h20, 32'h34, "rstctl");
      chk("rout", rout, 33'h1);
      // Hold bit re-latches while the seen flag still stands
      rd(8'h20, 32'h34, "rstctl");
      lm_u.hframe(3'h5, 1'b0, 6'h24);
      rd(8'h20, 32'h24, "rstctl");
      chk("rout", rout, 33'h0);
      rd(8'h20, 32'h4, "rstctl");
      // ==========================================
      // Sent reset words, software then pin driven
      wr(8'h20, 32'hFFFF_FF01);
      chk("rbit", rbit, 33'h0);
      wr(8'h20, 32'h3);
      chk("rbit", rbit, 33'h1);
      @(posedge clk) #1 sent = 1'b1;
      @(posedge clk) #1 sent = 1'b0;
      rd(8'h20, 32'hC3, "rstctl");
      rd(8'h20, 32'hC3, "rstctl");
      wr(8'h20, 32'hA);
      repeat (3) @(posedge clk);
      #1 chk("rbit", rbit, 33'h0);
      ext = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("rbit", rbit, 33'h1);
      rd(8'h20, 32'h8A, "rstctl");
      rd(8'h20, 32'hA, "rstctl");
      // ==========================================
      // Physical loopback and its resync flag
      // Drain the word left by earlier traffic, whose overruns set the flag
      @(posedge clk) #1 tx_stb = 1'b1;
      @(posedge clk) #1 tx_stb = 1'b0;
      rd(8'h24, 32'h11, "loop");
      rd(8'h24, 32'h1, "loop");
      lm_u.send(8'h00, 8'h5A, 1'b0);
      @(posedge clk) #1 tx_stb = 1'b1;
      @(posedge clk) #1 tx_stb = 1'b0;
      chk("tx_out", tx_out, 33'h5A);
      @(posedge clk) #1 tx_stb = 1'b1;
      @(posedge clk) #1 tx_stb = 1'b0;
      rd(8'h24, 32'h11, "loop");
      rd(8'h24, 32'h1, "loop");
      wr(8'h24, 32'h0);
      chk("floop", floop, 33'h5);
      @(posedge clk) #1 tx_stb = 1'b1;
      @(posedge clk) #1 tx_stb = 1'b0;
      chk("tx_out", tx_out, 33'hC3);
      wrap_up;
   end
endmodule

// ===== verilog/rlc_accept.v
// Purpose: Accepts a received value after repeated identical arrivals
// Assumes: STB pulses once per hyperframe carrying that frame's value
// Notes: Illegal values break the run and are never accepted
`timescale 1ns/100ps
`include "rlc_map.vh"

module rlc_accept #(
   parameter W = 6
) (
   // Clock and reset
   input wire CLK,
   input wire RST_N,
   // Sample in
   input wire STB,
   input wire LEGAL,
   input wire [W-1:0] VALUE,
   // Accepted value
   output reg [W-1:0] ACCEPTED,
   output reg VALID
);

   reg [W-1:0] last_q;
   reg [2:0] run_q;
   wire same = (VALUE == last_q) && (run_q != 3'h0);
   wire [2:0] run_d = same ? run_q + 3'h1 : 3'h1;

   // ==========================================
   // Run counter
   always @(posedge CLK) begin
      if (!RST_N) begin
         last_q <= {W{1'b0}};
         run_q <= 3'h0;
         ACCEPTED <= {W{1'b0}};
         VALID <= 1'b0;
      end else if (STB) begin
         if (!LEGAL) begin
            run_q <= 3'h0;
         end else begin
            last_q <= VALUE;
            // Saturate so a long steady run does not wrap
            run_q <= (run_d > `RLC_ACCEPT_COUNT) ? `RLC_ACCEPT_COUNT : run_d;
            if (run_d == `RLC_ACCEPT_COUNT) begin
               ACCEPTED <= VALUE;
               VALID <= 1'b1;
            end
         end
      end
   end

endmodule

// ===== verilog/rlc_map.vh
// Purpose: Register map and constants for the radio link reset/loop/mgmt bank
// Assumes: Byte addresses on the CPU port, 32-bit data words
// Notes: Definitions only
`ifndef RLC_MAP_VH
`define RLC_MAP_VH

// ==========================================
// Register offsets
`define RLC_OFS_LCV 8'h18
`define RLC_OFS_BFN 8'h1C
`define RLC_OFS_RST 8'h20
`define RLC_OFS_LOOP 8'h24
`define RLC_OFS_CMCFG 8'h28
`define RLC_OFS_CMSTAT 8'h2C

// ==========================================
// Reset control fields
`define RLC_RST_GEN_EN 0
`define RLC_RST_FORCE 1
`define RLC_RST_OUT_EN 2
`define RLC_RST_PIN_EN 3
`define RLC_RST_SEEN 4
`define RLC_RST_SEEN_HOLD 5
`define RLC_RST_SENT 6
`define RLC_RST_SENT_HOLD 7

// ==========================================
// Loopback and management fields
`define RLC_LOOP_SEL 0
`define RLC_LOOP_RESYNC 4
`define RLC_SLOW_LSB 8
`define RLC_SLOW_VALID 11
`define RLC_FAST_VALID 6

// ==========================================
// Reset values and limits
`define RLC_FAST_PTR_RST 6'h14
`define RLC_SLOW_RATE_RST 3'h0
`define RLC_LCV_MAX 8'hFF
`define RLC_FAST_PTR_MIN 6'h24
`define RLC_FAST_PTR_MAX 6'h3F
`define RLC_SLOW_RATE_MAX 3'h6
`define RLC_ACCEPT_COUNT 3'h4

// ==========================================
// Control byte positions within a hyperframe
`define RLC_Z_SLOW 8'h42
`define RLC_Z_RESET 8'h82
`define RLC_Z_FAST 8'hC2

`endif

// ===== verilog/rlc_regs.v
// Purpose: Link protocol register subset: violations, frame number, reset words,
//          physical loopback and management channel settings
// Assumes: Receive-side inputs change on the falling edge of RX_CLK
// Notes: RX_CLK is oversampled by CLK, no second clock domain here
`timescale 1ns/100ps
`include "rlc_map.vh"

// How it works
// - Count decoder violations in eight bits, sticking at 255 until reset.
// - The violation count drives nothing but its register; no loss-of-signal use.
// - Report the current node frame number, twelve bits, read-only.
// - Reset-sent flag rises when the transmitter reports a sent reset word.
// - Sent/seen flags latch into hold bits cleared by read; read twice.
// - Reset-seen flag follows the reset bit received at Z.130.0.
// - Pin-driven enable selects the external request input, ignoring software bits.
// - Software enable alone sends reset words as the force bit says.
// - Resync flag, cleared by read, sets on a loopback rate mismatch.
// - Loop select 0 passes normal data; 1 returns received words unchanged.
// - Loopback runs without frame sync, crossing only receive to transmit.
// - With loop select set the frame-level loop mode is forced to zero.
// - Configured slow rate goes out in control byte Z.66.0.
// - Configured fast pointer, default 14h, goes out in Z.194.0.
// - Slow rate accepted after four identical hyperframes, then marked valid.
// - Slow rate codes 000 to 110 are legal, 111 is not.
// - Fast pointer accepted after four identical values within 24h..3Fh.
// - Reserved bits read zero and ignore writes.
module rlc_regs (
   // Clock and reset
   input wire CLK,
   input wire RST_N,
   // CPU register port
   input wire [7:0] CPU_ADDR,
   input wire CPU_WR,
   input wire CPU_RD,
   input wire [31:0] CPU_WDATA,
   output reg [31:0] CPU_RDATA,
   output reg CPU_RVALID,
   // Receive link side, on the recovered clock
   input wire RX_CLK,
   input wire RX_LCV,
   input wire [7:0] RX_CTRL_IDX,
   input wire [7:0] RX_DATA,
   // Framer side, system clock
   input wire [11:0] RX_BFN,
   input wire [2:0] FRAME_LOOP_MODE_IN,
   output wire [2:0] FRAME_LOOP_MODE,
   // Transmit side, system clock
   input wire TX_STB,
   input wire [7:0] TX_DATA_IN,
   output reg [7:0] TX_DATA_OUT,
   input wire TX_RESET_SENT,
   output wire TX_RESET_BIT,
   output wire [2:0] SEND_SLOW_MGMT_RATE,
   output wire [5:0] SEND_FAST_MGMT_POINTER,
   output wire PHY_LOOP,
   // Reset handshake pins
   input wire EXTERNAL_RESET_REQUEST_IN,
   output wire RESET_OUT,
   // Accepted management settings
   output wire [2:0] ACCEPTED_SLOW_MGMT_RATE,
   output wire SLOW_RATE_ACCEPTED,
   output wire [5:0] ACCEPTED_FAST_MGMT_POINTER,
   output wire FAST_POINTER_ACCEPTED
);

   // ==========================================
   // Pin synchronisers
   reg [1:0] rxclk_sync_q;
   reg rxclk_prev_q;
   reg [1:0] lcv_sync_q;
   reg [7:0] idx_s1_q;
   reg [7:0] idx_s2_q;
   reg [7:0] dat_s1_q;
   reg [7:0] dat_s2_q;
   reg [1:0] ext_sync_q;

   always @(posedge CLK) begin
      if (!RST_N) begin
         // Reset high so an idle clock of either level gives no false rising edge
         rxclk_sync_q <= 2'h3;
         rxclk_prev_q <= 1'b1;
         lcv_sync_q <= 2'h0;
         idx_s1_q <= 8'h00;
         idx_s2_q <= 8'h00;
         dat_s1_q <= 8'h00;
         dat_s2_q <= 8'h00;
         ext_sync_q <= 2'h0;
      end else begin
         rxclk_sync_q <= {rxclk_sync_q[0], RX_CLK};
         rxclk_prev_q <= rxclk_sync_q[1];
         lcv_sync_q <= {lcv_sync_q[0], RX_LCV};
         idx_s1_q <= RX_CTRL_IDX;
         idx_s2_q <= idx_s1_q;
         dat_s1_q <= RX_DATA;
         dat_s2_q <= dat_s1_q;
         ext_sync_q <= {ext_sync_q[0], EXTERNAL_RESET_REQUEST_IN};
      end
   end

   // One receive word per synchronised rising edge of RX_CLK
   wire rx_edge = rxclk_sync_q[1] & ~rxclk_prev_q;
   wire ext_req = ext_sync_q[1];

   // ==========================================
   // CPU decode
   function sel;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         sel = (addr == ofs);
      end
   endfunction

   wire wr_rst = CPU_WR & sel(CPU_ADDR, `RLC_OFS_RST);
   wire wr_loop = CPU_WR & sel(CPU_ADDR, `RLC_OFS_LOOP);
   wire wr_cm = CPU_WR & sel(CPU_ADDR, `RLC_OFS_CMCFG);
   wire rd_rst = CPU_RD & sel(CPU_ADDR, `RLC_OFS_RST);
   wire rd_loop = CPU_RD & sel(CPU_ADDR, `RLC_OFS_LOOP);

   // ==========================================
   // Violation counter
   reg [7:0] lcv_cnt_q;

   always @(posedge CLK) begin
      if (!RST_N) begin
         lcv_cnt_q <= 8'h00;
      end else if (rx_edge && lcv_sync_q[1] && lcv_cnt_q != `RLC_LCV_MAX) begin
         lcv_cnt_q <= lcv_cnt_q + 8'h01;
      end
   end
   // Counts init-period violations too, so it stays out of loss detection.

   // ==========================================
   // Frame number
   reg [11:0] bfn_q;

   always @(posedge CLK) begin
      if (!RST_N) begin
         bfn_q <= 12'h000;
      end else begin
         bfn_q <= RX_BFN;
      end
   end

   // ==========================================
   // Reset control word handling
   reg gen_en_q;
   reg force_q;
   reg out_en_q;
   reg pin_en_q;
   reg seen_q;
   reg seen_hold_q;
   reg sent_q;
   reg sent_hold_q;

   always @(posedge CLK) begin
      if (!RST_N) begin
         gen_en_q <= 1'b0;
         force_q <= 1'b0;
         out_en_q <= 1'b0;
         pin_en_q <= 1'b0;
      end else if (wr_rst) begin
         gen_en_q <= CPU_WDATA[`RLC_RST_GEN_EN];
         force_q <= CPU_WDATA[`RLC_RST_FORCE];
         out_en_q <= CPU_WDATA[`RLC_RST_OUT_EN];
         pin_en_q <= CPU_WDATA[`RLC_RST_PIN_EN];
      end
   end

   always @(posedge CLK) begin
      if (!RST_N) begin
         seen_q <= 1'b0;
         sent_q <= 1'b0;
         seen_hold_q <= 1'b0;
         sent_hold_q <= 1'b0;
      end else begin
         if (rx_edge && idx_s2_q == `RLC_Z_RESET) begin
            seen_q <= dat_s2_q[0];
         end
         if (TX_RESET_SENT) begin
            sent_q <= 1'b1;
         end else if (!TX_RESET_BIT) begin
            sent_q <= 1'b0;
         end
         // New event beats the read clear
         seen_hold_q <= seen_q | (seen_hold_q & ~rd_rst);
         sent_hold_q <= sent_q | TX_RESET_SENT | (sent_hold_q & ~rd_rst);
      end
   end

   // Pin path outranks the software path
   assign TX_RESET_BIT = pin_en_q ? ext_req : (gen_en_q & force_q);
   // Acknowledge relies on the outside raising the request pin.
   assign RESET_OUT = out_en_q & seen_q;

   // ==========================================
   // Physical loopback
   reg loop_q;
   reg resync_q;
   reg [7:0] loop_byte_q;
   reg loop_full_q;

   always @(posedge CLK) begin
      if (!RST_N) begin
         loop_q <= 1'b0;
      end else if (wr_loop) begin
         loop_q <= CPU_WDATA[`RLC_LOOP_SEL];
      end
   end

   // Single-word hand-off from the receive edge to the transmit strobe.
   // Gives no elasticity: any rate difference shows as a resync.
   wire overrun = rx_edge & loop_full_q & ~TX_STB;
   wire underrun = TX_STB & ~loop_full_q & ~rx_edge;
   wire resync_evt = loop_q & (overrun | underrun);

   always @(posedge CLK) begin
      if (!RST_N) begin
         loop_byte_q <= 8'h00;
         loop_full_q <= 1'b0;
         resync_q <= 1'b0;
      end else begin
         if (rx_edge) begin
            loop_byte_q <= dat_s2_q;
         end
         if (rx_edge) begin
            loop_full_q <= 1'b1;
         end else if (TX_STB) begin
            loop_full_q <= 1'b0;
         end
         resync_q <= resync_evt | (resync_q & ~rd_loop);
      end
   end

   always @(posedge CLK) begin
      if (!RST_N) begin
         TX_DATA_OUT <= 8'h00;
      end else if (TX_STB) begin
         TX_DATA_OUT <= loop_q ? (rx_edge ? dat_s2_q : loop_byte_q) : TX_DATA_IN;
      end
   end

   assign PHY_LOOP = loop_q;
   assign FRAME_LOOP_MODE = loop_q ? 3'h0 : FRAME_LOOP_MODE_IN;

   // ==========================================
   // Management channel configuration
   reg [2:0] slow_rate_q;
   reg [5:0] fast_ptr_q;

   always @(posedge CLK) begin
      if (!RST_N) begin
         slow_rate_q <= `RLC_SLOW_RATE_RST;
         fast_ptr_q <= `RLC_FAST_PTR_RST;
      end else if (wr_cm) begin
         slow_rate_q <= CPU_WDATA[`RLC_SLOW_LSB+2:`RLC_SLOW_LSB];
         fast_ptr_q <= CPU_WDATA[5:0];
      end
   end

   assign SEND_SLOW_MGMT_RATE = slow_rate_q;
   assign SEND_FAST_MGMT_POINTER = fast_ptr_q;

   // ==========================================
   // Received management settings
   wire slow_stb = rx_edge & (idx_s2_q == `RLC_Z_SLOW);
   wire fast_stb = rx_edge & (idx_s2_q == `RLC_Z_FAST);
   wire slow_legal = dat_s2_q[2:0] <= `RLC_SLOW_RATE_MAX;
   wire fast_legal = dat_s2_q[5:0] >= `RLC_FAST_PTR_MIN &&
      dat_s2_q[5:0] <= `RLC_FAST_PTR_MAX && dat_s2_q[7:6] == 2'h0;

   rlc_accept #(.W(3)) u_slow (
      .CLK(CLK),
      .RST_N(RST_N),
      .STB(slow_stb),
      .LEGAL(slow_legal),
      .VALUE(dat_s2_q[2:0]),
      .ACCEPTED(ACCEPTED_SLOW_MGMT_RATE),
      .VALID(SLOW_RATE_ACCEPTED)
   );

   rlc_accept #(.W(6)) u_fast (
      .CLK(CLK),
      .RST_N(RST_N),
      .STB(fast_stb),
      .LEGAL(fast_legal),
      .VALUE(dat_s2_q[5:0]),
      .ACCEPTED(ACCEPTED_FAST_MGMT_POINTER),
      .VALID(FAST_POINTER_ACCEPTED)
   );

   // ==========================================
   // Read mux
   reg [31:0] rd_mux;

   always @* begin
      rd_mux = 32'h00000000;
      case (CPU_ADDR)
         `RLC_OFS_LCV: begin
            rd_mux[7:0] = lcv_cnt_q;
         end
         `RLC_OFS_BFN: begin
            rd_mux[11:0] = bfn_q;
         end
         `RLC_OFS_RST: begin
            rd_mux[`RLC_RST_GEN_EN] = gen_en_q;
            rd_mux[`RLC_RST_FORCE] = force_q;
            rd_mux[`RLC_RST_OUT_EN] = out_en_q;
            rd_mux[`RLC_RST_PIN_EN] = pin_en_q;
            rd_mux[`RLC_RST_SEEN] = seen_q;
            rd_mux[`RLC_RST_SEEN_HOLD] = seen_hold_q;
            rd_mux[`RLC_RST_SENT] = sent_q;
            rd_mux[`RLC_RST_SENT_HOLD] = sent_hold_q;
         end
         `RLC_OFS_LOOP: begin
            rd_mux[`RLC_LOOP_SEL] = loop_q;
            rd_mux[`RLC_LOOP_RESYNC] = resync_q;
         end
         `RLC_OFS_CMCFG: begin
            rd_mux[`RLC_SLOW_LSB+2:`RLC_SLOW_LSB] = slow_rate_q;
            rd_mux[5:0] = fast_ptr_q;
         end
         `RLC_OFS_CMSTAT: begin
            rd_mux[`RLC_SLOW_VALID] = SLOW_RATE_ACCEPTED;
            rd_mux[`RLC_SLOW_LSB+2:`RLC_SLOW_LSB] = ACCEPTED_SLOW_MGMT_RATE;
            rd_mux[`RLC_FAST_VALID] = FAST_POINTER_ACCEPTED;
            rd_mux[5:0] = ACCEPTED_FAST_MGMT_POINTER;
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   always @(posedge CLK) begin
      if (!RST_N) begin
         CPU_RDATA <= 32'h00000000;
         CPU_RVALID <= 1'b0;
      end else begin
         CPU_RVALID <= CPU_RD;
         if (CPU_RD) begin
            CPU_RDATA <= rd_mux;
         end
      end
   end

endmodule
